//--- core/compare_pkg.sv
// Constants and types for the output compare PWM channel
package compare_pkg;

    // ************************************************************
    // Register port geometry and register indices
    // ************************************************************
    localparam int         ADDR_W         = 3;
    localparam int         DATA_W         = 16;
    localparam logic [2:0] IDX_CTRL_ONE   = 3'h0;
    localparam logic [2:0] IDX_CTRL_TWO   = 3'h1;
    localparam logic [2:0] IDX_PRIMARY    = 3'h2;
    localparam logic [2:0] IDX_SECONDARY  = 3'h3;
    localparam logic [2:0] IDX_TIMER      = 3'h4;

    // ************************************************************
    // Control register one fields
    // ************************************************************
    localparam int          C1_MODE_LSB   = 0;
    localparam int          C1_TRIG_MODE  = 3;
    localparam int          C1_FAULT_STAT = 4;
    localparam int          C1_FAULT_EN   = 7;
    localparam logic [15:0] C1_WMASK      = 16'h3F8F;
    localparam logic [15:0] C1_RESET      = 16'h0000;

    // ************************************************************
    // Control register two fields
    // ************************************************************
    localparam int          C2_SRC_LSB    = 0;
    localparam int          C2_TRIS       = 5;
    localparam int          C2_TRIG_STAT  = 6;
    localparam int          C2_TRIG_SEL   = 7;
    localparam int          C2_CASCADE    = 8;
    localparam int          C2_DCB_LSB    = 9;
    localparam int          C2_INVERT     = 12;
    localparam int          C2_FLT_DIR    = 13;
    localparam int          C2_FLT_LVL    = 14;
    localparam int          C2_FLT_HOLD   = 15;
    localparam logic [15:0] C2_WMASK      = 16'hF7BF;
    localparam logic [15:0] C2_RESET      = 16'h000C;
    localparam logic [15:0] DATA_RESET    = 16'h0000;

    // ************************************************************
    // Source select codes and sub-cycle layout
    // ************************************************************
    localparam logic [4:0]  SRC_NONE      = 5'h00;
    localparam logic [4:0]  SRC_SELF      = 5'h1F;
    localparam int          SRC_COUNT     = 32;
    localparam int          QUARTERS      = 4;

    // Channel operating modes
    typedef enum logic [2:0] {
        MODE_OFF      = 3'b000,
        MODE_ONE_HIGH = 3'b001,
        MODE_ONE_LOW  = 3'b010,
        MODE_TOGGLE   = 3'b011,
        MODE_SHOT     = 3'b100,
        MODE_PULSES   = 3'b101,
        MODE_EDGE     = 3'b110,
        MODE_CENTRE   = 3'b111
    } mode_e;

endpackage

//--- core/output_compare_pwm_channel.sv
// Output compare channel with PWM, fault, sub-cycle edge and trigger logic
`timescale 1ns/1ps
`default_nettype none

module output_compare_pwm_channel
    import compare_pkg::*;
#(
    parameter int SOURCES = 32              // Width of the source pulse vector
) (
    input  wire logic                        ref_clk,          // System clock, 100 MHz
    input  wire logic                        reset,            // Synchronous, active high
    input  wire logic [compare_pkg::ADDR_W-1:0] regAddr,       // Register index
    input  wire logic [compare_pkg::DATA_W-1:0] regWrData,     // Write data
    input  wire logic                        regWr,            // Write strobe
    input  wire logic                        regRd,            // Read strobe
    output wire logic [compare_pkg::DATA_W-1:0] regRdData,     // Read data, next cycle
    input  wire logic [SOURCES-1:0]          syncSources,      // Source event pulses
    input  wire logic                        peerCarry,        // Low half rolled over
    input  wire logic                        peerMatch,        // Low half matches
    input  wire logic                        faultPin,         // Fault input, async
    output wire logic [compare_pkg::QUARTERS-1:0] compareOutputPin, // Quarter levels
    output wire logic                        pinOeN,           // Pin enable, low drives
    output wire logic                        matchOut,         // Primary equal, for peer
    output wire logic                        carryOut          // Rollover, for peer
);
    import compare_pkg::*;

    // Source vector must cover every select code
    if (SOURCES != SRC_COUNT) begin : g_bad_sources
        $error("SOURCES must equal 32");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] ctrlOne;
        logic [15:0] ctrlTwo;
        logic [15:0] primary;
        logic [15:0] secondary;
        logic [15:0] timer;
        logic [15:0] dutyBuf;
        logic [15:0] periodBuf;
        logic [1:0]  dcbBuf;
        logic [2:0]  modePrev;
        logic        level;
        logic        done;
        logic        faultS1;
        logic        faultS2;
        logic        faultS3;
        logic        faultLvl;
        logic        faultState;
        logic [3:0]  quarters;
        logic        oeN;
        logic [15:0] readData;
        logic        matchQ;
        logic        carryQ;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ************************************************************
    // Decoded fields and compare terms
    // ************************************************************
    mode_e       mode;
    logic        isPwm;
    logic        trigSel;
    logic        timer_trigger_status;
    logic        cascade;
    logic [4:0]  srcSel;
    logic        run;
    logic        step;
    logic        peerOk;
    logic [15:0] cmpPrim;
    logic [15:0] cmpSec;
    logic        evPrim;
    logic        evSec;
    logic        selfMatch;
    logic        srcPulse;
    logic        syncClear;
    logic        trigSet;
    logic        wrapNow;
    logic        wrOne;
    logic        wrTwo;
    logic        faultOn;
    logic        fell;
    logic [1:0]  dcbEff;
    logic        finalLvl;
    logic        invD;

    assign mode      = mode_e'(st_q.ctrlOne[C1_MODE_LSB +: 3]);
    assign isPwm     = (mode == MODE_EDGE) || (mode == MODE_CENTRE);
    assign trigSel   = st_q.ctrlTwo[C2_TRIG_SEL];
    assign timer_trigger_status  = st_q.ctrlTwo[C2_TRIG_STAT];
    assign cascade   = st_q.ctrlTwo[C2_CASCADE];
    assign srcSel    = st_q.ctrlTwo[C2_SRC_LSB +: 5];
    assign wrOne     = regWr && (regAddr == IDX_CTRL_ONE);
    assign wrTwo     = regWr && (regAddr == IDX_CTRL_TWO);

    // Timer runs when enabled and, in trigger mode, once triggered
    assign run       = (mode != MODE_OFF) && (!trigSel || timer_trigger_status);
    // Cascaded upper half only steps on the lower half's rollover
    assign step      = !cascade || peerCarry;
    assign peerOk    = !cascade || peerMatch;
    // PWM modes compare against the period-latched copies
    assign cmpPrim   = isPwm ? st_q.dutyBuf : st_q.primary;
    assign cmpSec    = isPwm ? st_q.periodBuf : st_q.secondary;
    assign evPrim    = run && peerOk && (st_q.timer == cmpPrim);
    assign evSec     = run && peerOk && (st_q.timer == cmpSec);
    assign selfMatch = st_q.timer == st_q.secondary;

    // Source mux; reserved codes simply carry no pulse from outside
    always_comb begin
        if (srcSel == SRC_NONE) begin
            srcPulse = 1'b0;
        end else if (srcSel == SRC_SELF) begin
            srcPulse = selfMatch && (mode != MODE_OFF);
        end else begin
            srcPulse = syncSources[srcSel];
        end
    end

    // Self as trigger starts only when secondary is zero (the held timer matches it), so software must avoid it
    assign trigSet   = trigSel && srcPulse && (mode != MODE_OFF);
    // Sync only makes sense for timer and channel sources
    assign syncClear = !trigSel && srcPulse;
    assign wrapNow   = run && (((mode == MODE_EDGE) && (st_q.timer == st_q.periodBuf))
                               || syncClear || (step && (&st_q.timer)));
    assign faultOn   = st_q.faultLvl && st_q.ctrlOne[C1_FAULT_EN] && isPwm;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        st_d = st_q;

        // Register writes; status bits handled apart below
        if (wrOne) begin
            st_d.ctrlOne = (regWrData & C1_WMASK) | (st_q.ctrlOne & ~C1_WMASK);
        end
        if (wrTwo) begin
            st_d.ctrlTwo = (regWrData & C2_WMASK) | (st_q.ctrlTwo & ~C2_WMASK);
        end
        if (regWr && (regAddr == IDX_PRIMARY)) begin
            st_d.primary = regWrData;
        end
        if (regWr && (regAddr == IDX_SECONDARY)) begin
            st_d.secondary = regWrData;
        end

        // Trigger status: hardware set wins over any clear
        if (trigSet) begin
            st_d.ctrlTwo[C2_TRIG_STAT] = 1'b1;
        end else if (wrTwo) begin
            st_d.ctrlTwo[C2_TRIG_STAT] = regWrData[C2_TRIG_STAT];
        end else if (st_q.ctrlOne[C1_TRIG_MODE] && selfMatch) begin
            st_d.ctrlTwo[C2_TRIG_STAT] = 1'b0;
        end

        // Timer held clear while idle or waiting for its trigger
        if (!run) begin
            st_d.timer = DATA_RESET;
        end else if (wrapNow) begin
            st_d.timer = DATA_RESET;
        end else if (step) begin
            st_d.timer = st_q.timer + 16'h0001;
        end

        // Duty, period and sub-cycle latch every cycle, but only at a period boundary while a PWM mode runs
        if (!isPwm || !run || wrapNow) begin
            st_d.dutyBuf   = st_q.primary;
            st_d.periodBuf = st_q.secondary;
            st_d.dcbBuf    = st_q.ctrlTwo[C2_DCB_LSB +: 2];
        end

        // Fault input: three stages, a change counts once 2 and 3 agree
        st_d.faultS1 = faultPin;
        st_d.faultS2 = st_q.faultS1;
        st_d.faultS3 = st_q.faultS2;
        if (st_q.faultS2 == st_q.faultS3) begin
            st_d.faultLvl = st_q.faultS3;
        end

        // Fault status: set wins; software clear, or period end in hold 0
        if (faultOn) begin
            st_d.ctrlOne[C1_FAULT_STAT] = 1'b1;
        end else if (wrOne && !regWrData[C1_FAULT_STAT]) begin
            st_d.ctrlOne[C1_FAULT_STAT] = 1'b0;
        end else if (!st_q.ctrlTwo[C2_FLT_HOLD] && st_q.faultState && wrapNow) begin
            st_d.ctrlOne[C1_FAULT_STAT] = 1'b0;
        end

        // Fault state leaves only after the input has gone away
        if (faultOn) begin
            st_d.faultState = 1'b1;
        end else if (st_q.ctrlTwo[C2_FLT_HOLD]) begin
            if (!st_d.ctrlOne[C1_FAULT_STAT]) begin
                st_d.faultState = 1'b0;
            end
        end else if (wrapNow || !isPwm) begin
            st_d.faultState = 1'b0;
        end

        // Output level per mode; a new mode restarts from its initial level
        st_d.modePrev = mode;
        if (mode != mode_e'(st_q.modePrev)) begin
            st_d.level = (mode == MODE_ONE_LOW);
            st_d.done  = 1'b0;
        end else begin
            case (mode)
                MODE_OFF: begin
                    st_d.level = 1'b0;
                end
                MODE_ONE_HIGH: begin
                    if (evPrim) begin
                        st_d.level = 1'b1;
                    end
                end
                MODE_ONE_LOW: begin
                    if (evPrim) begin
                        st_d.level = 1'b0;
                    end
                end
                MODE_TOGGLE: begin
                    if (evPrim) begin
                        st_d.level = !st_q.level;
                    end
                end
                MODE_SHOT: begin
                    // One pulse only, then parked low until the mode changes
                    if (!st_q.done && !st_q.level && evPrim) begin
                        st_d.level = 1'b1;
                    end else if (!st_q.done && st_q.level && evSec) begin
                        st_d.level = 1'b0;
                        st_d.done  = 1'b1;
                    end
                end
                MODE_PULSES: begin
                    if (!st_q.level && evPrim) begin
                        st_d.level = 1'b1;
                    end else if (st_q.level && evSec) begin
                        st_d.level = 1'b0;
                    end
                end
                MODE_EDGE: begin
                    // Zero duty stays low; duty past the period stays high
                    if (wrapNow) begin
                        st_d.level = (st_q.primary != DATA_RESET);
                    end else if (evPrim) begin
                        st_d.level = 1'b0;
                    end
                end
                MODE_CENTRE: begin
                    if (evSec) begin
                        st_d.level = 1'b0;
                    end else if (evPrim) begin
                        st_d.level = 1'b1;
                    end
                end
                default: begin
                    st_d.level = 1'b0;
                end
            endcase
        end

        // Quarter levels: the internal falling edge is held for dcb quarters
        invD     = st_d.ctrlTwo[C2_INVERT];
        dcbEff   = isPwm ? st_d.dcbBuf : st_d.ctrlTwo[C2_DCB_LSB +: 2];
        fell     = st_q.level && !st_d.level && !st_d.faultState
                   && (mode != MODE_ONE_HIGH);
        finalLvl = st_d.faultState ? st_d.ctrlTwo[C2_FLT_LVL]
                                   : (st_d.level ^ invD);
        for (int i = 0; i < QUARTERS; i++) begin
            // Inverted output turns the delayed edge into a rising one
            if (fell && (i < int'(dcbEff))) begin
                st_d.quarters[i] = !invD;
            end else begin
                st_d.quarters[i] = finalLvl;
            end
        end

        // Fault may force the pin out; otherwise tri-state bit decides
        if (st_d.faultState && st_d.ctrlTwo[C2_FLT_DIR]) begin
            st_d.oeN = 1'b0;
        end else begin
            st_d.oeN = st_d.ctrlTwo[C2_TRIS];
        end

        // Cascade hand-off to the partner channel
        st_d.matchQ = run && (st_q.timer == st_q.primary);
        st_d.carryQ = run && step && (&st_q.timer);

        // Read data stands for one cycle only; unmapped reads give zero
        st_d.readData = DATA_RESET;
        if (regRd) begin
            case (regAddr)
                IDX_CTRL_ONE:  st_d.readData = st_q.ctrlOne;
                IDX_CTRL_TWO:  st_d.readData = st_q.ctrlTwo;
                IDX_PRIMARY:   st_d.readData = st_q.primary;
                IDX_SECONDARY: st_d.readData = st_q.secondary;
                IDX_TIMER:     st_d.readData = st_q.timer;
                default:       st_d.readData = DATA_RESET;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q           <= '0;
            st_q.ctrlOne   <= C1_RESET;
            st_q.ctrlTwo   <= C2_RESET;
            st_q.oeN       <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign regRdData        = st_q.readData;
    assign compareOutputPin = st_q.quarters;
    assign pinOeN           = st_q.oeN;
    assign matchOut         = st_q.matchQ;
    assign carryOut         = st_q.carryQ;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    logic modeSteady;
    assign modeSteady = (mode == mode_e'(st_q.modePrev)) && !wrOne;

    a_disabled_idle: assert property (
        (mode == MODE_OFF) && !wrOne |=> (st_q.timer == DATA_RESET) && !st_q.level)
        else $error("disabled channel not idle");

    a_single_rise: assert property (
        (mode == MODE_ONE_HIGH) && modeSteady && evPrim |=> st_q.level [*2])
        else $error("mode 001 event did not raise output");

    a_single_fall: assert property (
        (mode == MODE_ONE_LOW) && modeSteady && evPrim |=> !st_q.level)
        else $error("mode 010 event did not lower output");

    a_toggle_step: assert property (
        (mode == MODE_TOGGLE) && modeSteady && evPrim |=> st_q.level != $past(st_q.level))
        else $error("mode 011 event did not toggle");

    sequence s_shot_high;
        (mode == MODE_SHOT) && modeSteady && st_q.level && evSec;
    endsequence
    sequence s_shot_parked;
        st_q.done && !st_q.level;
    endsequence
    a_shot_once: assert property (
        s_shot_high |=> s_shot_parked ##1 (!st_q.level || !modeSteady))
        else $error("single shot did not end");

    a_fault_level: assert property (
        st_q.faultState |-> compareOutputPin == {QUARTERS{st_q.ctrlTwo[C2_FLT_LVL]}})
        else $error("fault level not on output");

    a_fault_drive: assert property (
        st_q.faultState && st_q.ctrlTwo[C2_FLT_DIR] |-> !pinOeN)
        else $error("fault did not force output");

    a_tris_release: assert property (
        st_q.ctrlTwo[C2_TRIS] && !st_q.faultState |-> pinOeN)
        else $error("tri-state bit ignored");

    a_trig_hold: assert property (
        trigSel && !timer_trigger_status && !trigSet |=> st_q.timer == DATA_RESET)
        else $error("timer ran before trigger");

    a_trig_hwclear: assert property (
        st_q.ctrlOne[C1_TRIG_MODE] && selfMatch && !trigSet && !wrTwo |=> !timer_trigger_status)
        else $error("secondary match did not clear trigger status");

    a_dcb_buffer: assert property (
        isPwm && run && !wrapNow && !$past(wrOne) |=> $stable(st_q.dcbBuf))
        else $error("sub-cycle field changed mid-period");

    a_edge_delay: assert property (
        st_q.level && !st_d.level && !st_d.faultState && isPwm && !invD && !wrOne
        && (st_d.dcbBuf == 2'h2) |=> compareOutputPin == 4'h3)
        else $error("falling edge not delayed by half cycle");

endmodule

`default_nettype wire

//--- verif/pin_load_model.sv
// Load model on the channel's output pin, with a weak pull-down
`timescale 1ns/1ps
`default_nettype none

module pin_load_model (
    input  wire logic [3:0] compareOutputPin, // Quarter levels from channel
    input  wire logic       pinOeN,           // Low while channel drives
    output var  logic       pinLevel          // Level the load sees
);
    // Released pin falls to the pull-down, never keeps the stale level
    always_comb pinLevel = pinOeN ? 1'b0 : compareOutputPin[3];
endmodule

`default_nettype wire

//--- verif/output_compare_pwm_channel_test.sv
// Self-checking bench for the output compare PWM channel
`timescale 1ns/1ps
`default_nettype none

module output_compare_pwm_channel_test;
    import compare_pkg::*;
    logic        ref_clk, reset, regWr, regRd, faultPin, pinOeN, pinLevel;
    logic        peerCarry, peerMatch, matchOut, carryOut;
    logic [2:0]  regAddr;
    logic [15:0] regWrData, regRdData;
    logic [31:0] syncSources;
    logic [3:0]  compareOutputPin;
    int          errTotal = 0;
    int          checksDone = 0;

    output_compare_pwm_channel output_compare_pwm_channel_inst (
        .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .syncSources(syncSources),
        .peerCarry(peerCarry), .peerMatch(peerMatch), .faultPin(faultPin),
        .compareOutputPin(compareOutputPin), .pinOeN(pinOeN), .matchOut(matchOut),
        .carryOut(carryOut));
    pin_load_model pin_load_model_inst (
        .compareOutputPin(compareOutputPin), .pinOeN(pinOeN), .pinLevel(pinLevel));

    // ************************************************************
    // Bus and checking tasks
    // ************************************************************
    task automatic finish_test();
        $display("Counts: %0d mismatches in %0d checks", errTotal, checksDone);
        if (errTotal == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A gap edge before each strobe keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    task automatic waitNext(input logic [3:0] exp);
        logic [3:0] cur;
        int         i;
        #1 cur = compareOutputPin;
        i = 0;
        while (compareOutputPin === cur && i < 40) begin
            @(posedge ref_clk);
            #1 i++;
        end
        if (i == 40) begin
            errTotal++;
            finish_test();
        end
        chk({12'h000, compareOutputPin}, {12'h000, exp});
    endtask
    // Primary 8 and secondary 12 leave room to see the initial level
    task automatic runMode(input logic [15:0] c1, input logic [15:0] c2,
                           input logic [3:0] start, input logic [11:0] seq, input int n);
        wr(IDX_CTRL_ONE, 16'h0000);
        wr(IDX_CTRL_TWO, c2);
        wr(IDX_PRIMARY, 16'h0008);
        wr(IDX_SECONDARY, 16'h000C);
        wr(IDX_CTRL_ONE, c1);
        repeat (4) @(posedge ref_clk);
        #1 chk({12'h000, compareOutputPin}, {12'h000, start});
        for (int k = 0; k < n; k++) waitNext(seq[4*k+:4]);
        $display("Mode test %h done", c1);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic regTest();
        rdReg(IDX_CTRL_TWO, 16'h000C);
        wr(IDX_TIMER, 16'h1234);
        rdReg(IDX_TIMER, 16'h0000);
        rdReg(3'h5, 16'h0000);
        wr(IDX_CTRL_TWO, 16'hFFBF);
        rdReg(IDX_CTRL_TWO, 16'hF7BF);
        wr(IDX_CTRL_ONE, 16'hFFFF);
        rdReg(IDX_CTRL_ONE, 16'h3F8F);
        $display("Register test done");
    endtask
    // Upper half of a cascade: steps only on peer carry, matches need peer match
    task automatic cascadeTest();
        runMode(16'h0001, 16'h0100, 4'h0, 12'h000, 0);
        rdReg(IDX_TIMER, 16'h0000);
        @(posedge ref_clk);
        peerCarry <= 1'b1;
        @(posedge ref_clk);
        peerCarry <= 1'b0;
        rdReg(IDX_TIMER, 16'h0001);
        wr(IDX_PRIMARY, 16'h0001);
        repeat (3) @(posedge ref_clk);
        #1 chk({10'h000, compareOutputPin, matchOut, carryOut}, 16'h0002);
        @(posedge ref_clk);
        peerMatch <= 1'b1;
        waitNext(4'hF);
        @(posedge ref_clk);
        peerMatch <= 1'b0;
        $display("Cascade test done");
    endtask
    // Timer source as trigger, never self nor a trigger-only source
    task automatic trigTest();
        runMode(16'h0001, 16'h008B, 4'h0, 12'h000, 0);
        rdReg(IDX_TIMER, 16'h0000);
        @(posedge ref_clk);
        syncSources <= 32'h0000_0800;
        @(posedge ref_clk);
        syncSources <= 32'h0000_0000;
        rdReg(IDX_CTRL_TWO, 16'h00CB);
        waitNext(4'hF);
        wr(IDX_CTRL_TWO, 16'h00EB);
        repeat (3) @(posedge ref_clk);
        #1 chk({14'h0000, pinOeN, pinLevel}, 16'h0002);
        $display("Trigger test done");
    endtask
    task automatic faultTest();
        runMode(16'h0087, 16'h4000, 4'h0, 12'h00F, 2);
        @(posedge ref_clk);
        faultPin <= 1'b1;
        waitNext(4'hF);
        rdReg(IDX_CTRL_ONE, 16'h0097);
        @(posedge ref_clk);
        faultPin <= 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 chk({12'h000, compareOutputPin}, 16'h000F);
        wr(IDX_CTRL_ONE, 16'h0000);
        waitNext(4'h0);
        $display("Fault test done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        reset = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 3'h0;
        regWrData = 16'h0000;
        syncSources = 32'h0000_0000;
        faultPin = 1'b0;
        peerCarry = 1'b0;
        peerMatch = 1'b0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        regTest();
        runMode(16'h0001, 16'h0000, 4'h0, 12'h00F, 1);
        runMode(16'h0002, 16'h0400, 4'hF, 12'h003, 2);
        runMode(16'h0003, 16'h0000, 4'h0, 12'h00F, 1);
        runMode(16'h0004, 16'h0000, 4'h0, 12'h00F, 2);
        runMode(16'h0005, 16'h0000, 4'h0, 12'h00F, 2);
        runMode(16'h0001, 16'h1600, 4'hF, 12'h000, 1);
        runMode(16'h0006, 16'h0000, 4'h0, 12'hF0F, 3);
        cascadeTest();
        trigTest();
        faultTest();
        finish_test();
    end
endmodule

`default_nettype wire
